//--- pkg/touch_defs.svh
// Timing and sizing constants for the touch burst and sync controller
`ifndef TOUCH_DEFS_SVH
`define TOUCH_DEFS_SVH

// ****************************************************************
// Clock
// ****************************************************************
`define CLK_PERIOD_NS 20
`define CLK_KHZ 50000

// ****************************************************************
// Burst and sleep timing
// ****************************************************************
`define SLEEP_TIMEOUT_MS 90
`define CHARGE_PULSE_NS 2000
`define SS_CLAMP_NS 8000
`define BURST_PULSES 400
`define OSC_PERIOD_RESET 16'h01f4

// ****************************************************************
// Timebase for recalibration and drift
// ****************************************************************
`define FAST_UNIT_TICKS 1000
`define FAST_UNIT_MS 10
`define SYNC_RATE_HZ 55
`define STUCK_SHORT_S 10
`define STUCK_LONG_S 60
`define DRIFT_NEG_MS 250
`define DRIFT_POS_PER_NEG 4

// ****************************************************************
// Consensus filter
// ****************************************************************
`define CONSENSUS_LEN 6

`endif

//--- pkg/touch_pkg.sv
// Types shared by the touch burst controller and its filters
package touch_pkg;

    // ****************************************************************
    // Enumerations
    // ****************************************************************
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_BURST,
        ST_CLAMP,
        ST_SLEEP
    } burst_state_type;

    typedef enum logic [1:0] {
        STUCK_10S,
        STUCK_60S,
        STUCK_INF
    } stuck_mode_type;

    // ****************************************************************
    // State records
    // ****************************************************************
    typedef struct packed {
        burst_state_type state;
        logic sync_meta;
        logic sync_sync;
        logic sync_prev;
        logic slow_mode;
        stuck_mode_type stuck_sel;
        logic sync_present;
        logic [22:0] wait_cnt;
        logic [15:0] osc_cnt;
        logic [8:0] pulse_cnt;
        logic [6:0] charge_cnt;
        logic charge;
        logic [9:0] unit_cnt;
        logic [1:0][12:0] stuck_cnt;
        logic [4:0] drift_cnt;
        logic [1:0] drift_sub;
        logic [1:0] recal_req;
        logic drift_neg;
        logic drift_pos;
        logic ss_out;
        logic ss_oe_n;
        logic osc_run;
        logic sample;
        logic [1:0] detect;
        logic [1:0] key_out;
    } ctrl_state_type;

    typedef struct packed {
        logic [2:0] count;
        logic key;
    } filter_state_type;

endpackage

//--- pkg/filter_if.sv
// Link between the burst controller and one channel's consensus filter
interface filter_if;
    logic sample;
    logic detect;
    logic clear;
    logic key;
    logic pending;

    modport ctrl (
        output sample,
        output detect,
        output clear,
        input key,
        input pending
    );

    modport filt (
        input sample,
        input detect,
        input clear,
        output key,
        output pending
    );
endinterface

//--- src/consensus_filter.sv
// Per-channel consensus filter over successive burst results
`include "touch_defs.svh"

module consensus_filter (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Controller side
    filter_if.filt link
);
    import touch_pkg::*;

    filter_state_type s;
    filter_state_type next_s;

    // Count agreeing samples; one miss drops the pending detection
    always_comb begin
        next_s = s;
        if (link.clear) begin
            next_s.count = 3'h0;
            next_s.key = 1'b0;
        end else if (link.sample) begin
            if (!link.detect) begin
                next_s.count = 3'h0;
                next_s.key = 1'b0;
            end else if (s.count < 3'(`CONSENSUS_LEN - 1)) begin
                next_s.count = s.count + 3'h1;
            end else begin
                next_s.count = 3'(`CONSENSUS_LEN);
                next_s.key = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign link.key = s.key;
    assign link.pending = (s.count != 3'h0) && !s.key;
endmodule

//--- src/touch_burst_sync_control.sv
// Burst scheduler, sync/spread pin and timebase for a two-key sensor
`include "touch_defs.svh"

module touch_burst_sync_control #(
    parameter int unsigned SLEEP_CYCLES = `SLEEP_TIMEOUT_MS * `CLK_KHZ
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Straps
    input wire logic speed_slow,
    input wire logic [1:0] opt_strap,
    // Oscillator period in sys_clk cycles, from the bias setting
    input wire logic [15:0] bias_osc_pin,
    // Shared sync / spread pin
    input wire logic sync_ss_in,
    output logic sync_ss_out,
    output logic sync_ss_oe_n,
    // Sensing front end
    output logic [1:0] sense_pin,
    output logic osc_run,
    input wire logic [1:0] chan_detect,
    // Results
    output logic [1:0] key_out,
    output logic [1:0] recal_req,
    output logic drift_neg_step,
    output logic drift_pos_step,
    output logic sync_present
);
    import touch_pkg::*;

    // ****************************************************************
    // Derived counts
    // ****************************************************************
    localparam logic [6:0] CHARGE_CYC =
        7'((`CHARGE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS);
    localparam logic [22:0] CLAMP_CYC =
        23'((`SS_CLAMP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS);
    localparam logic [22:0] SLEEP_LAST = 23'(SLEEP_CYCLES - 1);
    localparam logic [8:0] PULSES = 9'(`BURST_PULSES);
    localparam logic [9:0] UNIT_LAST = 10'(`FAST_UNIT_TICKS - 1);
    localparam int SHORT_MS = `STUCK_SHORT_S * 1000;
    localparam int LONG_MS = `STUCK_LONG_S * 1000;
    localparam int HALF_SLEEP = `SLEEP_TIMEOUT_MS / 2;
    localparam logic [12:0] FAST_SHORT = 13'(SHORT_MS / `FAST_UNIT_MS);
    localparam logic [12:0] FAST_LONG = 13'(LONG_MS / `FAST_UNIT_MS);
    localparam logic [12:0] SLOW_SHORT =
        13'((SHORT_MS + HALF_SLEEP) / `SLEEP_TIMEOUT_MS);
    localparam logic [12:0] SLOW_LONG =
        13'((LONG_MS + HALF_SLEEP) / `SLEEP_TIMEOUT_MS);
    localparam logic [12:0] SYNC_SHORT =
        13'(`STUCK_SHORT_S * `SYNC_RATE_HZ);
    localparam logic [12:0] SYNC_LONG =
        13'(`STUCK_LONG_S * `SYNC_RATE_HZ);
    localparam logic [4:0] DRIFT_FAST =
        5'(`DRIFT_NEG_MS / `FAST_UNIT_MS);
    localparam logic [4:0] DRIFT_SLOW =
        5'((`DRIFT_NEG_MS + HALF_SLEEP) / `SLEEP_TIMEOUT_MS);
    localparam logic [4:0] DRIFT_SYNC =
        5'((`DRIFT_NEG_MS * `SYNC_RATE_HZ + 500) / 1000);
    localparam logic [1:0] DRIFT_SUB_LAST = 2'(`DRIFT_POS_PER_NEG - 1);

    // ****************************************************************
    // Limit selection
    // ****************************************************************

    // Stuck-key limit in timebase units for mode, sync and strap
    function automatic logic [12:0] stuck_limit(
        input logic slow,
        input logic sync,
        input stuck_mode_type sel
    );
        logic [12:0] lim;
        lim = FAST_SHORT;
        if (!slow) begin
            lim = (sel == STUCK_60S) ? FAST_LONG : FAST_SHORT;
        end else if (sync) begin
            lim = (sel == STUCK_60S) ? SYNC_LONG : SYNC_SHORT;
        end else begin
            lim = (sel == STUCK_60S) ? SLOW_LONG : SLOW_SHORT;
        end
        return lim;
    endfunction

    // Drift step length in timebase units
    function automatic logic [4:0] drift_limit(
        input logic slow,
        input logic sync
    );
        logic [4:0] lim;
        lim = DRIFT_FAST;
        if (slow) begin
            lim = sync ? DRIFT_SYNC : DRIFT_SLOW;
        end
        return lim;
    endfunction

    // ****************************************************************
    // Filters
    // ****************************************************************
    ctrl_state_type s;
    ctrl_state_type next_s;
    filter_if link0 ();
    filter_if link1 ();
    logic [1:0] filt_key;
    logic [1:0] filt_pending;

    consensus_filter filter0 (
        .sys_clk(sys_clk),
        .rst(rst),
        .link(link0.filt)
    );

    consensus_filter filter1 (
        .sys_clk(sys_clk),
        .rst(rst),
        .link(link1.filt)
    );

    // Both filters take the same burst strobe
    assign link0.sample = s.sample;
    assign link0.detect = s.detect[0];
    assign link0.clear = s.recal_req[0];
    assign link1.sample = s.sample;
    assign link1.detect = s.detect[1];
    assign link1.clear = s.recal_req[1];
    assign filt_key = {link1.key, link0.key};
    assign filt_pending = {link1.pending, link0.pending};

    // ****************************************************************
    // Next state
    // ****************************************************************
    logic sync_rise;
    logic osc_tick;
    logic unit_tick;
    logic [12:0] stuck_lim;
    logic [4:0] drift_lim;

    // Scheduler, sync handling, timebase and stuck-key timers
    always_comb begin
        next_s = s;
        next_s.sample = 1'b0;
        next_s.recal_req = 2'h0;
        next_s.drift_neg = 1'b0;
        next_s.drift_pos = 1'b0;
        // Straps follow the pins; changes take effect on the next cycle
        next_s.slow_mode = speed_slow;
        case (opt_strap)
            2'b10: next_s.stuck_sel = STUCK_60S;
            2'b00: next_s.stuck_sel = STUCK_INF;
            default: next_s.stuck_sel = STUCK_10S;
        endcase
        // Two-stage synchroniser, edge taken from the second stage
        next_s.sync_meta = sync_ss_in;
        next_s.sync_sync = s.sync_meta;
        next_s.sync_prev = s.sync_sync;
        sync_rise = s.sync_sync && !s.sync_prev;
        osc_tick = (s.state == ST_BURST) && (s.osc_cnt == 16'h0000);
        unit_tick = 1'b0;
        stuck_lim = stuck_limit(s.slow_mode, s.sync_present, s.stuck_sel);
        drift_lim = drift_limit(s.slow_mode, s.sync_present);
        next_s.key_out = filt_key;

        case (s.state)
            ST_IDLE: begin
                next_s.state = ST_BURST;
                next_s.osc_cnt = 16'h0000;
                next_s.pulse_cnt = 9'h000;
                next_s.osc_run = 1'b1;
                // First burst drives the pin too; slow mode clears it below
                next_s.ss_out = 1'b1;
            end
            ST_BURST: begin
                // Free-running period counter; pulses one period apart
                if (s.osc_cnt >= bias_osc_pin - 16'h0001) begin
                    next_s.osc_cnt = 16'h0000;
                end else begin
                    next_s.osc_cnt = s.osc_cnt + 16'h0001;
                end
                if (osc_tick && (s.pulse_cnt != PULSES)) begin
                    next_s.charge = 1'b1;
                    next_s.charge_cnt = CHARGE_CYC - 7'h01;
                    next_s.pulse_cnt = s.pulse_cnt + 9'h001;
                end else if (s.charge_cnt != 7'h00) begin
                    next_s.charge_cnt = s.charge_cnt - 7'h01;
                end else begin
                    next_s.charge = 1'b0;
                end
                // Burst done: sample both channels together
                if ((s.pulse_cnt == PULSES) && !s.charge) begin
                    next_s.state = ST_CLAMP;
                    next_s.wait_cnt = 23'h000000;
                    next_s.sample = 1'b1;
                    next_s.detect = chan_detect;
                    next_s.ss_out = 1'b0;
                    unit_tick = s.slow_mode;
                end
            end
            ST_CLAMP: begin
                next_s.wait_cnt = s.wait_cnt + 23'h000001;
                if (s.wait_cnt >= CLAMP_CYC - 23'h000001) begin
                    next_s.osc_cnt = 16'h0000;
                    next_s.pulse_cnt = 9'h000;
                    next_s.wait_cnt = 23'h000000;
                    // Pending detections are confirmed without sleeping
                    if (s.slow_mode && (filt_pending == 2'h0)) begin
                        next_s.state = ST_SLEEP;
                        next_s.osc_run = 1'b0;
                    end else begin
                        next_s.state = ST_BURST;
                        next_s.ss_out = !s.slow_mode;
                    end
                end
            end
            ST_SLEEP: begin
                next_s.wait_cnt = s.wait_cnt + 23'h000001;
                if (!s.slow_mode) begin
                    next_s.state = ST_BURST;
                    next_s.osc_run = 1'b1;
                    next_s.ss_out = 1'b1;
                end else if (sync_rise) begin
                    // Edges seen outside sleep are dropped
                    next_s.state = ST_BURST;
                    next_s.osc_run = 1'b1;
                    next_s.sync_present = 1'b1;
                end else if (s.wait_cnt >= SLEEP_LAST) begin
                    next_s.state = ST_BURST;
                    next_s.osc_run = 1'b1;
                    next_s.sync_present = 1'b0;
                end
            end
            default: begin
                next_s.state = ST_IDLE;
            end
        endcase

        // Pin drive only in fast mode; slow mode leaves it an input
        next_s.ss_oe_n = next_s.slow_mode;
        if (next_s.slow_mode) begin
            next_s.ss_out = 1'b0;
        end
        if (!s.slow_mode) begin
            next_s.sync_present = 1'b0;
        end

        // Fast mode unit is a fixed count of oscillator periods
        if (!s.slow_mode && osc_tick) begin
            if (s.unit_cnt >= UNIT_LAST) begin
                next_s.unit_cnt = 10'h000;
                unit_tick = 1'b1;
            end else begin
                next_s.unit_cnt = s.unit_cnt + 10'h001;
            end
        end

        // Drift step pulses: negative each step, positive every fourth
        if (unit_tick) begin
            if (s.drift_cnt >= drift_lim - 5'h01) begin
                next_s.drift_cnt = 5'h00;
                next_s.drift_neg = 1'b1;
                next_s.drift_sub = s.drift_sub + 2'h1;
                next_s.drift_pos = (s.drift_sub == DRIFT_SUB_LAST);
            end else begin
                next_s.drift_cnt = s.drift_cnt + 5'h01;
            end
        end

        // Stuck-key timers run only while a key is active
        for (int ch = 0; ch < 2; ch++) begin
            if (!filt_key[ch] || (s.stuck_sel == STUCK_INF)) begin
                next_s.stuck_cnt[ch] = 13'h0000;
            end else if (unit_tick) begin
                if (s.stuck_cnt[ch] >= stuck_lim - 13'h0001) begin
                    next_s.stuck_cnt[ch] = 13'h0000;
                    next_s.recal_req[ch] = 1'b1;
                end else begin
                    next_s.stuck_cnt[ch] = s.stuck_cnt[ch] + 13'h0001;
                end
            end
        end
    end

    // ****************************************************************
    // State register and outputs
    // ****************************************************************

    // Whole controller state
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s <= '0;
            s.state <= ST_IDLE;
            s.stuck_sel <= STUCK_10S;
            s.ss_oe_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // Outputs taken directly from state flops
    assign sync_ss_out = s.ss_out;
    assign sync_ss_oe_n = s.ss_oe_n;
    assign sense_pin = {s.charge, s.charge};
    assign osc_run = s.osc_run;
    assign key_out = s.key_out;
    assign recal_req = s.recal_req;
    assign drift_neg_step = s.drift_neg;
    assign drift_pos_step = s.drift_pos;
    assign sync_present = s.sync_present;
endmodule

//--- testbench/touch_sync_asserts.sv
// Checker for burst pulses, shared pin drive and sleep wake behaviour
module touch_sync_asserts #(
    parameter int unsigned SLEEP_CYCLES = 4500000
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Straps and inputs
    input wire logic speed_slow,
    input wire logic [1:0] opt_strap,
    input wire logic [15:0] bias_osc_pin,
    input wire logic sync_ss_in,
    input wire logic [1:0] chan_detect,
    // Outputs under watch
    input wire logic sync_ss_out,
    input wire logic sync_ss_oe_n,
    input wire logic [1:0] sense_pin,
    input wire logic osc_run,
    input wire logic [1:0] key_out,
    input wire logic [1:0] recal_req,
    input wire logic drift_neg_step,
    input wire logic drift_pos_step,
    input wire logic sync_present
);
    // ****************************************************************
    // Helper counters
    // ****************************************************************
    logic prev_sense;
    logic [15:0] per_cnt;
    logic [7:0] hi_cnt;
    logic [31:0] slp_cnt;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // Pulse spacing, pulse width and sleep length counters
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prev_sense <= 1'b0;
            per_cnt <= 16'hffff;
            hi_cnt <= 8'h00;
            slp_cnt <= 32'h0;
        end else begin
            prev_sense <= sense_pin[0];
            if (sense_pin[0] && !prev_sense) begin
                per_cnt <= 16'h0001;
            end else if (per_cnt != 16'hffff) begin
                per_cnt <= per_cnt + 16'h0001;
            end
            hi_cnt <= sense_pin[0] ? hi_cnt + 8'h01 : 8'h00;
            slp_cnt <= osc_run ? 32'h0 : slp_cnt + 32'h1;
        end
    end

    a_fast_pin_drive: assert property (
        !speed_slow && !$past(speed_slow) && !$past(rst) |-> !sync_ss_oe_n)
        else $error("shared pin not driven in fast mode");
    a_slow_pin_input: assert property (
        speed_slow && $past(speed_slow) |-> sync_ss_oe_n && !sync_ss_out)
        else $error("shared pin driven in slow mode");
    a_channels_lockstep: assert property (
        sense_pin[0] == sense_pin[1])
        else $error("channels pulse out of step");
    a_fast_osc_runs: assert property (
        !speed_slow && !$past(speed_slow) && !$past(rst) |-> osc_run)
        else $error("oscillator stopped in fast mode");
    a_sleep_quiet: assert property (
        !osc_run |-> sense_pin == 2'b00)
        else $error("charge pulse while oscillator stopped");
    a_pulse_width: assert property (
        !sense_pin[0] && prev_sense |-> hi_cnt == 8'h64)
        else $error("charge pulse width wrong");
    a_pulse_spacing: assert property (
        sense_pin[0] && !prev_sense && per_cnt <= bias_osc_pin
        |-> per_cnt == bias_osc_pin)
        else $error("charge pulses closer than one period");
    a_sleep_bound: assert property (
        slp_cnt <= SLEEP_CYCLES + 2)
        else $error("sleep outlasted the internal timeout");
    a_sync_wake: assert property (
        speed_slow && !osc_run && slp_cnt > 32'h4 && $rose(sync_ss_in)
        |-> ##[2:6] (osc_run && sync_present))
        else $error("sync edge did not wake the device");
    a_fast_no_sync: assert property (
        !speed_slow && !$past(speed_slow) |=> !sync_present)
        else $error("sync flagged in fast mode");
    a_drift_pair: assert property (
        drift_pos_step |-> drift_neg_step)
        else $error("positive drift step without negative step");
endmodule

bind touch_burst_sync_control touch_sync_asserts #(
    .SLEEP_CYCLES(SLEEP_CYCLES)
) i_touch_sync_asserts (
    .sys_clk(sys_clk),
    .rst(rst),
    .speed_slow(speed_slow),
    .opt_strap(opt_strap),
    .bias_osc_pin(bias_osc_pin),
    .sync_ss_in(sync_ss_in),
    .chan_detect(chan_detect),
    .sync_ss_out(sync_ss_out),
    .sync_ss_oe_n(sync_ss_oe_n),
    .sense_pin(sense_pin),
    .osc_run(osc_run),
    .key_out(key_out),
    .recal_req(recal_req),
    .drift_neg_step(drift_neg_step),
    .drift_pos_step(drift_pos_step),
    .sync_present(sync_present)
);

//--- testbench/sync_source.sv
// External sync source model standing on the shared pin
module sync_source #(
    parameter int HOLD = 50
) (
    // Clock and request
    input wire logic sys_clk,
    input wire logic fire,
    // Pin drive level
    output logic sync_level
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;

    // Holds the pin high for HOLD cycles per request, no modulation
    always @(posedge sys_clk) begin
        if (fire) begin
            cnt <= HOLD;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end

    // Idle level is low; pulses are spaced wider than a burst by the bench
    assign sync_level = (cnt > 0);
endmodule

//--- testbench/testbench.sv
// Self-checking bench for the burst and sync controller
`include "touch_defs.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // Signals and monitors
    // ****************************************************************
    localparam int unsigned SLEEP = 2000;
    localparam logic [15:0] BIAS = 16'h0065;
    localparam int CLAMP = `SS_CLAMP_NS / `CLK_PERIOD_NS;
    logic sys_clk = 1'b0, rst = 1'b1, speed_slow = 1'b0, fire = 1'b0;
    logic [1:0] opt_strap = 2'b01, chan_detect = 2'b00;
    logic sync_level, sync_ss_in, sync_ss_out, sync_ss_oe_n, osc_run;
    logic drift_neg_step, drift_pos_step, sync_present, prev_sense = 1'b0;
    logic [1:0] sense_pin, key_out, recal_req;
    int errors = 0, n_compared = 0, cyc = 0, rises = 0, last = 0, gap = 0;
    int steps = 0;

    always #10 sys_clk = ~sys_clk;
    // Shared pin level from both drivers
    assign sync_ss_in = sync_ss_oe_n ? sync_level : sync_ss_out;

    // Counts charge pulse rises and the spacing of the last two
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        prev_sense <= sense_pin[0];
        // Any drift or recalibration pulse is counted
        if (drift_neg_step || drift_pos_step || recal_req != 2'b00) begin
            steps <= steps + 1;
        end
        if (rst) begin
            rises <= 0;
        end else if (sense_pin[0] && !prev_sense) begin
            rises <= rises + 1;
            gap <= cyc - last;
            last <= cyc;
        end
    end

    touch_burst_sync_control #(.SLEEP_CYCLES(SLEEP)) i_touch_burst_sync_control (
        .sys_clk(sys_clk), .rst(rst), .speed_slow(speed_slow),
        .opt_strap(opt_strap), .bias_osc_pin(BIAS), .sync_ss_in(sync_ss_in),
        .sync_ss_out(sync_ss_out), .sync_ss_oe_n(sync_ss_oe_n),
        .sense_pin(sense_pin), .osc_run(osc_run), .chan_detect(chan_detect),
        .key_out(key_out), .recal_req(recal_req),
        .drift_neg_step(drift_neg_step), .drift_pos_step(drift_pos_step),
        .sync_present(sync_present)
    );
    sync_source #(.HOLD(50)) i_sync_source (
        .sys_clk(sys_clk), .fire(fire), .sync_level(sync_level)
    );

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic complete_run;
        $display("Comparisons %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic check_bit(input logic got, input logic exp, string what);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask

    task automatic check_count(input logic [31:0] got, exp, string what);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: %s got %0d", $time, what, got);
        end
    endtask

    // Counts cycles until oscillator (0) or pin drive (1) reaches level
    task automatic wait_sig(input int which, input logic lvl, input int bound,
                            output int n);
        n = 0;
        while ((which == 0 ? osc_run : sync_ss_out) !== lvl) begin
            if (n >= bound) begin
                errors++;
                $display("CHECK FAILED at %0t: wait timed out", $time);
                complete_run();
            end
            @(posedge sys_clk);
            #1;
            n++;
        end
    endtask

    // Holds reset eight cycles, checks idle outputs, then releases
    task automatic apply_reset(input logic slow);
        @(posedge sys_clk);
        rst <= 1'b1;
        speed_slow <= slow;
        repeat (8) @(posedge sys_clk);
        check_bit(sync_ss_oe_n, 1'b1, "pin enabled in reset");
        check_count({sense_pin, key_out, osc_run, sync_present}, 0,
                    "outputs busy in reset");
        rst <= 1'b0;
    endtask

    task automatic pulse_sync;
        @(posedge sys_clk);
        fire <= 1'b1;
        @(posedge sys_clk);
        fire <= 1'b0;
        #1;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic test_fast_burst;
        int n;
        apply_reset(1'b0);
        chan_detect <= 2'b01;
        for (n = 0; n < 1000 && rises < 2; n++) @(posedge sys_clk);
        if (rises < 2) begin
            errors++;
            $display("CHECK FAILED at %0t: pulse wait timed out", $time);
            complete_run();
        end
        #1;
        check_count(gap, BIAS, "first pulse spacing");
        check_bit(sync_ss_oe_n, 1'b0, "pin not driven");
        check_bit(sync_ss_out, 1'b1, "pin low in burst");
        wait_sig(1, 1'b0, 45000, n);
        check_count(rises, `BURST_PULSES, "pulses per burst");
        wait_sig(1, 1'b1, 1000, n);
        check_count(n, CLAMP, "clamp length");
        check_bit(osc_run, 1'b1, "no back-to-back burst");
        check_bit(sync_present, 1'b0, "own pulse taken as sync");
        check_count(key_out, 0, "key after one detect");
    endtask

    task automatic test_slow_sleep;
        int n;
        apply_reset(1'b1);
        chan_detect <= 2'b00;
        wait_sig(0, 1'b1, 10, n);
        wait_sig(0, 1'b0, 45000, n);
        check_bit(sync_ss_oe_n, 1'b1, "pin driven in sleep");
        check_bit(sync_ss_out, 1'b0, "spread drive in slow");
        wait_sig(0, 1'b1, SLEEP + 10, n);
        check_bit(n >= SLEEP && n <= SLEEP + 2, 1'b1,
                  "sleep timeout length");
        check_bit(sync_present, 1'b0, "sync flag without sync");
        repeat (100) @(posedge sys_clk);
        pulse_sync();
        wait_sig(0, 1'b0, 45000, n);
        repeat (100) @(posedge sys_clk);
        #1;
        check_bit(osc_run, 1'b0, "burst edge remembered");
        pulse_sync();
        wait_sig(0, 1'b1, 10, n);
        check_bit(n <= 8, 1'b1, "sync wake latency");
        check_bit(sync_present, 1'b1, "sync flag after wake");
        // Two slow burst ends are fewer than one drift step's units
        check_count(steps, 0, "early drift or recal step");
    endtask

    initial begin
        test_fast_burst();
        test_slow_sleep();
        complete_run();
    end
endmodule
